// file: twe_ctrl_model.sv
/*
  Two-wire bus controller model: drives scl and releases or pulls sda.
  Assumes a pull-up on sda; every step is taken on a clk edge.
*/
`timescale 1ns/1ps
module twe_ctrl_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_rel
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  // Also serves as repeated start from scl low
  task automatic start();
    sda_rel <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_rel <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_rel <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_rel <= 1'b1;
    half();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_rel <= b;
    half();
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
    half();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, r);
  endtask
  task automatic select(input logic [3:0] fam, input logic [2:0] s, input logic rd,
                        output logic ack);
    wbyte({fam, s, rd}, ack);
  endtask
  task automatic point(input logic [15:0] a, output logic ack);
    logic k;
    wbyte(a[15:8], k);
    wbyte(a[7:0], ack);
    ack = ack && k;
  endtask
endmodule

// file: twe_eeprom_target.sv
/*
  Target side of a two-wire serial EEPROM: bit engine on the serial clock,
  byte array, page buffer and self-timed programming on the system clock.
  Assumes sda_i is the resolved bus level (pull-up outside) and that the
  strap and write-inhibit pads have pull-downs, modelled here as any level
  other than a clean one reading as low.
*/
`timescale 1ns/1ps
module twe_eeprom_target #(
  parameter int unsigned WR_CYCLES  = twe_pkg::WR_CYCLES,
  parameter int unsigned FIFO_DEPTH = twe_pkg::FIFO_DEPTH
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     scl,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe,
  input  wire logic [twe_pkg::SEL_W-1:0] chip_select_straps,
  input  wire logic                     write_inhibit
);

  localparam int unsigned SEL_W   = twe_pkg::SEL_W;
  localparam int unsigned BYTE_W  = twe_pkg::BYTE_W;
  localparam int unsigned ADDR_W  = twe_pkg::ADDR_W;
  localparam int unsigned PAGE_W  = twe_pkg::PAGE_W;
  localparam int unsigned WORD_W  = twe_pkg::WORD_W;
  localparam int unsigned WAIT_N  = (WR_CYCLES > twe_pkg::PAGE_BYTES + 1) ?
                                    (WR_CYCLES - twe_pkg::PAGE_BYTES) : 1;
  localparam logic [31:0] WAIT_LAST = 32'(WAIT_N - 1);
  localparam logic [PAGE_W-1:0] IDX_LAST = {PAGE_W{1'b1}};

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: bus conditions
  logic                 start_tgl_q;
  logic                 stop_tgl_q;

  // Start: SDA falls while SCL is high
  always_ff @(negedge sda_i or posedge rst) begin
    if (rst) begin
      start_tgl_q <= 1'b0;
    end else if (scl) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // Stop: SDA rises while SCL is high
  always_ff @(posedge sda_i or posedge rst) begin
    if (rst) begin
      stop_tgl_q <= 1'b0;
    end else if (scl) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: receive side, rising SCL
  twe_pkg::twe_link_t   link_q;
  logic                 start_seen_q;
  logic [3:0]           bit_q;
  logic [BYTE_W-1:0]    shift_q;
  logic                 ack_q;
  logic                 push_q;
  logic [WORD_W-1:0]    push_word_q;
  logic [SEL_W-1:0]     strap_s1_q;
  logic [SEL_W-1:0]     strap_q;
  logic                 busy_s1_q;
  logic                 busy_l_q;
  logic [BYTE_W-1:0]    rx_byte;
  logic                 start_pend;
  logic                 sel_match;
  logic                 fifo_w_ready;
  logic [BYTE_W-1:0]    rd_byte_q;
  logic                 busy_q;

  assign rx_byte    = {shift_q[BYTE_W-2:0], sda_i};
  assign start_pend = (start_tgl_q != start_seen_q);
  assign sel_match  = (rx_byte[BYTE_W-1:twe_pkg::FAM_LSB] == twe_pkg::FAMILY_CODE) &&
                      (rx_byte[twe_pkg::FAM_LSB-1:twe_pkg::SEL_LSB] == strap_q);

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      strap_s1_q <= '0;
      strap_q    <= '0;
      busy_s1_q  <= 1'b0;
      busy_l_q   <= 1'b0;
    end else begin
      for (int i = 0; i < SEL_W; i++) begin
        strap_s1_q[i] <= (chip_select_straps[i] === 1'b1);
      end
      strap_q   <= strap_s1_q;
      busy_s1_q <= busy_q;
      busy_l_q  <= busy_s1_q;
    end
  end

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      link_q       <= twe_pkg::LNK_IDLE;
      start_seen_q <= 1'b0;
      bit_q        <= twe_pkg::BIT_FIRST;
      shift_q      <= '0;
      ack_q        <= 1'b0;
      push_q       <= 1'b0;
      push_word_q  <= '0;
    end else begin
      push_q <= 1'b0;
      if (start_pend) begin
        start_seen_q <= start_tgl_q;
        link_q       <= twe_pkg::LNK_DEV;
        bit_q        <= twe_pkg::BIT_AFTER_START;
        shift_q      <= {{(BYTE_W-1){1'b0}}, sda_i};
        ack_q        <= 1'b0;
      end else if (link_q != twe_pkg::LNK_IDLE) begin
        if (bit_q == twe_pkg::BIT_ACK) begin
          bit_q <= twe_pkg::BIT_FIRST;
          // Controller leaves SDA high after a read byte: read ends
          if (link_q == twe_pkg::LNK_RD && !ack_q && sda_i) begin
            link_q <= twe_pkg::LNK_IDLE;
          end
        end else if (bit_q == twe_pkg::BIT_LAST) begin
          bit_q <= twe_pkg::BIT_ACK;
          ack_q <= 1'b0;
          case (link_q)
            twe_pkg::LNK_DEV: begin
              if (sel_match && !busy_l_q) begin
                ack_q <= 1'b1;
                if (rx_byte[twe_pkg::DIR_POS]) begin
                  link_q <= twe_pkg::LNK_RD;
                end else begin
                  link_q <= twe_pkg::LNK_AHI;
                end
              end else begin
                link_q <= twe_pkg::LNK_IDLE;
              end
            end
            twe_pkg::LNK_AHI: begin
              if (fifo_w_ready) begin
                ack_q       <= 1'b1;
                push_q      <= 1'b1;
                push_word_q <= {twe_pkg::KIND_AHI, rx_byte};
                link_q      <= twe_pkg::LNK_ALO;
              end else begin
                link_q <= twe_pkg::LNK_IDLE;
              end
            end
            twe_pkg::LNK_ALO: begin
              if (fifo_w_ready) begin
                ack_q       <= 1'b1;
                push_q      <= 1'b1;
                push_word_q <= {twe_pkg::KIND_ALO, rx_byte};
                link_q      <= twe_pkg::LNK_WR;
              end else begin
                link_q <= twe_pkg::LNK_IDLE;
              end
            end
            twe_pkg::LNK_WR: begin
              // Any number of data bytes; partial pages need nothing extra
              if (fifo_w_ready) begin
                ack_q       <= 1'b1;
                push_q      <= 1'b1;
                push_word_q <= {twe_pkg::KIND_DATA, rx_byte};
              end else begin
                link_q <= twe_pkg::LNK_IDLE;
              end
            end
            twe_pkg::LNK_RD: begin
              ack_q <= 1'b0;
            end
            default: begin
              link_q <= twe_pkg::LNK_IDLE;
            end
          endcase
        end else begin
          bit_q   <= bit_q + 4'h1;
          shift_q <= rx_byte;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: transmit side, falling SCL
  logic [BYTE_W-1:0]    tx_q;
  logic                 rd_req_q;
  logic                 sda_oe_q;

  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      tx_q     <= '0;
      rd_req_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_pend || link_q == twe_pkg::LNK_IDLE) begin
      sda_oe_q <= 1'b0;
    end else if (bit_q == twe_pkg::BIT_ACK) begin
      sda_oe_q <= ack_q;
    end else if (link_q == twe_pkg::LNK_RD) begin
      if (bit_q == twe_pkg::BIT_FIRST) begin
        // Prefetched byte is stable here; ask for the next one
        tx_q     <= {rd_byte_q[BYTE_W-2:0], 1'b0};
        sda_oe_q <= ~rd_byte_q[BYTE_W-1];
        rd_req_q <= ~rd_req_q;
      end else begin
        tx_q     <= {tx_q[BYTE_W-2:0], 1'b0};
        sda_oe_q <= ~tx_q[BYTE_W-1];
      end
    end else begin
      sda_oe_q <= 1'b0;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // Crossing FIFO for address and data bytes
  logic                 fifo_r_valid;
  logic                 fifo_r_ready;
  logic [WORD_W-1:0]    fifo_r_data;
  logic                 fifo_pop;
  logic [1:0]           r_kind;
  logic [BYTE_W-1:0]    r_byte;

  twe_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .w_clk   (scl),
    .r_clk   (clk),
    .rst     (rst),
    .w_valid (push_q),
    .w_ready (fifo_w_ready),
    .w_data  (push_word_q),
    .r_valid (fifo_r_valid),
    .r_ready (fifo_r_ready),
    .r_data  (fifo_r_data)
  );

  assign r_kind   = fifo_r_data[WORD_W-1:BYTE_W];
  assign r_byte   = fifo_r_data[BYTE_W-1:0];
  assign fifo_pop = fifo_r_valid & fifo_r_ready;

  //////////////////////////////////////////////////////////////////////////////
  // System domain: synchronisers
  logic                 wp_s1_q;
  logic                 wp_q;
  logic [2:0]           stop_sync_q;
  logic [2:0]           rdreq_sync_q;
  logic                 stop_evt;
  logic                 rd_evt;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_s1_q      <= 1'b0;
      wp_q         <= 1'b0;
      stop_sync_q  <= '0;
      rdreq_sync_q <= '0;
    end else begin
      wp_s1_q      <= (write_inhibit === 1'b1);
      wp_q         <= wp_s1_q;
      stop_sync_q  <= {stop_sync_q[1:0], stop_tgl_q};
      rdreq_sync_q <= {rdreq_sync_q[1:0], rd_req_q};
    end
  end

  assign stop_evt = stop_sync_q[2] ^ stop_sync_q[1];
  assign rd_evt   = rdreq_sync_q[2] ^ rdreq_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // System domain: address pointer and page buffer
  twe_pkg::twe_prog_t   prog_q;
  logic [ADDR_W-1:0]    ptr_q;
  logic [twe_pkg::PAGE_BYTES-1:0] mask_q;
  logic [BYTE_W-1:0]    page_q [twe_pkg::PAGE_BYTES];
  logic [BYTE_W-1:0]    mem_q  [twe_pkg::MEM_BYTES];
  logic [PAGE_W-1:0]    idx_q;
  logic [31:0]          wait_q;
  logic                 stop_pend_q;
  logic                 commit;
  logic                 drop;

  assign fifo_r_ready = (prog_q == twe_pkg::PRG_IDLE);
  assign commit       = (prog_q == twe_pkg::PRG_IDLE) && stop_pend_q && !fifo_r_valid;
  assign drop         = commit && (wp_q || (mask_q == '0));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_q  <= '0;
      mask_q <= '0;
    end else begin
      if (fifo_pop) begin
        case (r_kind)
          twe_pkg::KIND_AHI: begin
            ptr_q[ADDR_W-1:BYTE_W] <= r_byte[twe_pkg::HI_USED_W-1:0];
            mask_q                 <= '0;
          end
          twe_pkg::KIND_ALO: begin
            ptr_q[BYTE_W-1:0] <= r_byte;
          end
          twe_pkg::KIND_DATA: begin
            mask_q[ptr_q[PAGE_W-1:0]] <= 1'b1;
            ptr_q[PAGE_W-1:0]         <= ptr_q[PAGE_W-1:0] + 1'b1;
          end
          default: begin
            ptr_q <= ptr_q;
          end
        endcase
      end else if (rd_evt) begin
        ptr_q <= ptr_q + 1'b1;
      end
      if (drop || (prog_q == twe_pkg::PRG_COPY && idx_q == IDX_LAST)) begin
        mask_q <= '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (fifo_pop && r_kind == twe_pkg::KIND_DATA) begin
      page_q[ptr_q[PAGE_W-1:0]] <= r_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System domain: array and read prefetch
  always_ff @(posedge clk) begin
    if (prog_q == twe_pkg::PRG_COPY && mask_q[idx_q]) begin
      mem_q[{ptr_q[ADDR_W-1:PAGE_W], idx_q}] <= page_q[idx_q];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_byte_q <= '0;
    end else begin
      rd_byte_q <= mem_q[ptr_q];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // System domain: self-timed programming
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_q      <= twe_pkg::PRG_IDLE;
      stop_pend_q <= 1'b0;
      idx_q       <= '0;
      wait_q      <= '0;
      busy_q      <= 1'b0;
    end else begin
      if (stop_evt) begin
        stop_pend_q <= 1'b1;
      end
      case (prog_q)
        twe_pkg::PRG_IDLE: begin
          if (commit) begin
            // A stop arriving now stays pending
            stop_pend_q <= stop_evt;
            if (!drop) begin
              prog_q <= twe_pkg::PRG_COPY;
              idx_q  <= '0;
              busy_q <= 1'b1;
            end
          end
        end
        twe_pkg::PRG_COPY: begin
          idx_q <= idx_q + 1'b1;
          if (idx_q == IDX_LAST) begin
            prog_q <= twe_pkg::PRG_WAIT;
            wait_q <= '0;
          end
        end
        twe_pkg::PRG_WAIT: begin
          wait_q <= wait_q + 32'h0000_0001;
          if (wait_q == WAIT_LAST) begin
            prog_q <= twe_pkg::PRG_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          prog_q <= twe_pkg::PRG_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: twe_fifo.sv
/*
  Dual-clock FIFO with gray-coded pointers, valid and ready on both sides.
  Assumes DEPTH is a power of two of at least four and that one reset
  covers both clock domains.
*/
`timescale 1ns/1ps
module twe_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             w_clk,
  input  wire logic             r_clk,
  input  wire logic             rst,
  input  wire logic             w_valid,
  output logic                  w_ready,
  input  wire logic [WIDTH-1:0] w_data,
  output logic                  r_valid,
  input  wire logic             r_ready,
  output logic      [WIDTH-1:0] r_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wbin_q;
  logic [AW:0]      wgray_q;
  logic [AW:0]      rbin_q;
  logic [AW:0]      rgray_q;
  logic [AW:0]      wg_s1_q;
  logic [AW:0]      wg_s2_q;
  logic [AW:0]      rg_s1_q;
  logic [AW:0]      rg_s2_q;
  logic [AW:0]      wbin_d;
  logic [AW:0]      rbin_d;
  logic             do_w;
  logic             do_r;

  assign wbin_d  = wbin_q + {{AW{1'b0}}, 1'b1};
  assign rbin_d  = rbin_q + {{AW{1'b0}}, 1'b1};
  assign w_ready = (wgray_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
  assign r_valid = (rgray_q != wg_s2_q);
  assign do_w    = w_valid & w_ready;
  assign do_r    = r_valid & r_ready;
  assign r_data  = mem_q[rbin_q[AW-1:0]];

  //////////////////////////////////////////////////////////////////////////////
  // Fill side
  always_ff @(posedge w_clk) begin
    if (do_w) begin
      mem_q[wbin_q[AW-1:0]] <= w_data;
    end
  end

  always_ff @(posedge w_clk or posedge rst) begin
    if (rst) begin
      wbin_q  <= '0;
      wgray_q <= '0;
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
      if (do_w) begin
        wbin_q  <= wbin_d;
        wgray_q <= wbin_d ^ (wbin_d >> 1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Drain side
  always_ff @(posedge r_clk or posedge rst) begin
    if (rst) begin
      rbin_q  <= '0;
      rgray_q <= '0;
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end else begin
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
      if (do_r) begin
        rbin_q  <= rbin_d;
        rgray_q <= rbin_d ^ (rbin_d >> 1);
      end
    end
  end

endmodule

// file: twe_monitor.sv
/*
  Port checker of the two-wire EEPROM target.
  Assumes scl and sda_i only change on system clock edges.
*/
`timescale 1ns/1ps
module twe_monitor (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       scl,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic [2:0] chip_select_straps,
  input wire logic       write_inhibit
);
  logic       tog_q;
  logic       seen_q;
  logic       first_q;
  logic       ack_q;
  logic       rd_q;
  logic [3:0] slot_q;
  logic [7:0] sh_q;
  logic [2:0] sel;
  logic       nw;
  logic       match;

  ////////////////////////////////////////////////////////////////////////////
  // Start flag toggles, bit slots counted on scl rise
  always_ff @(negedge sda_i or posedge rst) begin
    if (rst) tog_q <= 1'b0;
    else if (scl) tog_q <= ~tog_q;
  end
  assign nw = tog_q != seen_q;
  assign sel = {chip_select_straps[2] === 1'b1, chip_select_straps[1] === 1'b1,
                chip_select_straps[0] === 1'b1};
  assign match = sh_q[7:4] == 4'hA && sh_q[3:1] == sel;
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
      slot_q <= 4'h0;
      sh_q <= 8'h00;
      first_q <= 1'b0;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      seen_q <= tog_q;
      sh_q <= {sh_q[6:0], sda_i};
      slot_q <= (nw || slot_q == 4'h9) ? 4'h1 : slot_q + 4'h1;
      first_q <= nw || (first_q && slot_q != 4'h9);
      if (nw) ack_q <= 1'b0;
      else if (first_q && slot_q == 4'h8) begin
        ack_q <= sda_oe;
        rd_q <= sh_q[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_sda_low_only: assert property (
    @(posedge clk) disable iff (rst) sda_oe |-> !sda_o) else $error("sda driven high");
  a_change_on_fall: assert property (
    @(posedge clk) disable iff (rst) $changed(sda_oe) |-> !scl) else $error("sda moved, scl high");
  a_reset_quiet: assert property (
    @(posedge clk) disable iff (rst) $fell(rst) |-> !sda_oe [*3]) else $error("busy after reset");
  a_addr_quiet: assert property (
    @(posedge scl) disable iff (rst) (nw || (first_q && slot_q < 4'h8)) |-> !sda_oe)
    else $error("driven in address byte");
  a_ack_match: assert property (
    @(posedge scl) disable iff (rst) (first_q && slot_q == 4'h8 && sda_oe) |-> match)
    else $error("ack without match");
  a_nak_hold: assert property (
    @(posedge scl) disable iff (rst) (first_q && slot_q == 4'h8 && !match) |-> !sda_oe ##1 !sda_oe)
    else $error("mismatch not released");
  a_data_ack: assert property (
    @(posedge scl) disable iff (rst) (ack_q && !rd_q && !first_q && slot_q == 4'h8) |-> sda_oe)
    else $error("write byte not acked");
  a_data_quiet: assert property (
    @(posedge scl) disable iff (rst) (!rd_q && !first_q && !nw && slot_q != 4'h8) |-> !sda_oe)
    else $error("driven in write data");
endmodule

// file: twe_pkg.sv
/*
  Shared constants and types of the two-wire EEPROM target: array geometry,
  address byte layout, bit slot positions, FIFO word layout, write timing
  and the state encodings of the link and the programming engine.
  Assumes a 200 MHz system clock.
*/
package twe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned ADDR_W     = 15;
  localparam int unsigned PAGE_W     = 6;
  localparam int unsigned PAGE_BYTES = 64;
  localparam int unsigned PAGE_COUNT = 512;
  localparam int unsigned MEM_BYTES  = PAGE_BYTES * PAGE_COUNT;
  localparam int unsigned HI_USED_W  = ADDR_W - BYTE_W;

  ////////////////////////////////////////////////////////////////////////////
  // Address byte layout
  localparam int unsigned SEL_W       = 3;
  localparam int unsigned DIR_POS     = 0;
  localparam int unsigned SEL_LSB     = 1;
  localparam int unsigned FAM_LSB     = 4;
  localparam logic [3:0]  FAMILY_CODE = 4'hA;

  ////////////////////////////////////////////////////////////////////////////
  // Bit slots within one byte on the link
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_AFTER_START = 4'h1;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Write cycle timing
  localparam int unsigned WR_TIME_MS = 5;
  localparam int unsigned CLK_KHZ    = 200000;
  localparam int unsigned WR_CYCLES  = WR_TIME_MS * CLK_KHZ;

  ////////////////////////////////////////////////////////////////////////////
  // FIFO word: kind tag above one byte
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned KIND_W     = 2;
  localparam int unsigned WORD_W     = KIND_W + BYTE_W;
  localparam logic [1:0]  KIND_AHI   = 2'h1;
  localparam logic [1:0]  KIND_ALO   = 2'h2;
  localparam logic [1:0]  KIND_DATA  = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // State encodings
  typedef enum logic [5:0] {
    LNK_IDLE = 6'h01,
    LNK_DEV  = 6'h02,
    LNK_AHI  = 6'h04,
    LNK_ALO  = 6'h08,
    LNK_WR   = 6'h10,
    LNK_RD   = 6'h20
  } twe_link_t;

  typedef enum logic [2:0] {
    PRG_IDLE = 3'h1,
    PRG_COPY = 3'h2,
    PRG_WAIT = 3'h4
  } twe_prog_t;

endpackage

// file: two_wire_eeprom_slave_interface_tb.sv
/*
  Testbench of the two-wire EEPROM target, driven by a controller model.
  Assumes a write cycle shortened to WRC system clocks.
*/
`timescale 1ns/1ps
module two_wire_eeprom_slave_interface_tb;
  localparam int WRC = 200;
  logic       clk;
  logic       rst;
  logic       scl;
  logic       sda_rel;
  logic       sda_oe;
  logic       sda_o;
  logic [2:0] straps;
  logic [2:0] sel;
  logic       wp;
  wire        sda = sda_rel && !(sda_oe && !sda_o);
  int         miscompares;
  int         tests_run;

  twe_eeprom_target #(.WR_CYCLES(WRC)) i_twe_eeprom_target (
    .clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .chip_select_straps(straps), .write_inhibit(wp));
  twe_ctrl_model i_twe_ctrl_model (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk1(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus frames
  task automatic probe(input logic [3:0] fam, input logic [2:0] s, input logic e);
    logic k;
    i_twe_ctrl_model.start();
    i_twe_ctrl_model.select(fam, s, 1'b0, k);
    i_twe_ctrl_model.stop();
    chk1("probe ack", e, k);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d[3], input int n);
    logic k;
    i_twe_ctrl_model.start();
    i_twe_ctrl_model.select(4'hA, sel, 1'b0, k);
    chk1("addr ack", 1'b1, k);
    i_twe_ctrl_model.point(a, k);
    chk1("word ack", 1'b1, k);
    for (int i = 0; i < n; i++) begin
      i_twe_ctrl_model.wbyte(d[i], k);
      chk1("data ack", 1'b1, k);
    end
    i_twe_ctrl_model.stop();
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    logic       k;
    logic [7:0] g;
    i_twe_ctrl_model.start();
    i_twe_ctrl_model.select(4'hA, sel, 1'b0, k);
    i_twe_ctrl_model.point(a, k);
    i_twe_ctrl_model.start();
    i_twe_ctrl_model.select(4'hA, sel, 1'b1, k);
    chk1("read ack", 1'b1, k);
    i_twe_ctrl_model.rbyte(1'b0, g);
    i_twe_ctrl_model.stop();
    chk8("read byte", e, g);
  endtask
  // Two bytes in one read frame: controller ACKs the first, NAKs the second
  task automatic rd2(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic       k;
    logic [7:0] g;
    i_twe_ctrl_model.start();
    i_twe_ctrl_model.select(4'hA, sel, 1'b0, k);
    i_twe_ctrl_model.point(a, k);
    i_twe_ctrl_model.start();
    i_twe_ctrl_model.select(4'hA, sel, 1'b1, k);
    chk1("seq read ack", 1'b1, k);
    i_twe_ctrl_model.rbyte(1'b1, g);
    chk8("seq byte 0", e0, g);
    i_twe_ctrl_model.rbyte(1'b0, g);
    i_twe_ctrl_model.stop();
    chk8("seq byte 1", e1, g);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic sc_page();
    wr(16'h803E, '{8'h11, 8'h22, 8'h33}, 3);
    probe(4'hA, sel, 1'b0);
    repeat (WRC) @(posedge clk);
    probe(4'hA, sel, 1'b1);
    rd(16'h003E, 8'h11);
    rd(16'h003F, 8'h22);
    rd(16'h0000, 8'h33);
    rd2(16'h003E, 8'h11, 8'h22);
  endtask
  task automatic sc_select();
    for (int s = 0; s < 8; s++) probe(4'hA, s[2:0], s == 5);
    probe(4'h5, 3'h5, 1'b0);
  endtask
  task automatic sc_inhibit();
    wr(16'h1234, '{8'hC3, 8'h00, 8'h00}, 1);
    repeat (WRC + 20) @(posedge clk);
    wp <= 1'b1;
    wr(16'h1234, '{8'h5A, 8'h00, 8'h00}, 1);
    probe(4'hA, sel, 1'b1);
    rd(16'h1234, 8'hC3);
    wp <= 1'b0;
  endtask
  task automatic sc_float();
    straps <= 3'hZ;
    sel = 3'h0;
    wp <= 1'hZ;
    wr(16'h7FFF, '{8'h96, 8'h00, 8'h00}, 1);
    repeat (WRC + 20) @(posedge clk);
    rd(16'h7FFF, 8'h96);
    straps <= 3'h5;
    sel = 3'h5;
    wp <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    straps = 3'h5;
    sel = 3'h5;
    wp = 1'b0;
    miscompares = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    sc_page();
    sc_select();
    sc_inhibit();
    sc_float();
    conclude();
  end

  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule

bind twe_eeprom_target twe_monitor i_twe_monitor (
  .clk(clk), .rst(rst), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .chip_select_straps(chip_select_straps), .write_inhibit(write_inhibit));
